//--- include/supervisor_pkg.sv
package supervisor_pkg;

   // ------------------------------------------------------------------
   // Timebase
   // ------------------------------------------------------------------
   localparam int CLK_HZ         = 20_000_000;
   localparam int TICK_HZ        = 1_000;
   localparam int TICK_CYCLES    = CLK_HZ / TICK_HZ;

   // ------------------------------------------------------------------
   // Reset hold window, in milliseconds
   // ------------------------------------------------------------------
   localparam int RESET_HOLD_MIN_MS = 140;
   localparam int RESET_HOLD_MS     = 200;
   localparam int RESET_HOLD_MAX_MS = 280;
   localparam int RESET_HOLD_TICKS  = RESET_HOLD_MS * TICK_HZ / 1_000;

   // ------------------------------------------------------------------
   // Watchdog expiry window, in milliseconds
   // ------------------------------------------------------------------
   localparam int WDOG_MIN_MS    = 1_120;
   localparam int WDOG_MS        = 1_600;
   localparam int WDOG_MAX_MS    = 2_400;
   localparam int WDOG_TICKS     = WDOG_MS * TICK_HZ / 1_000;

   // ------------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------------
   localparam logic MR_IDLE      = 1'h1;
   localparam logic SUPPLY_IDLE  = 1'h1;
   localparam logic KICK_IDLE    = 1'h0;
   localparam logic FLOAT_IDLE   = 1'h1;

   typedef enum logic [1:0] {
      ST_RESET,
      ST_HOLD,
      ST_RUN
   } sup_state_t;

endpackage

//--- design/pin_sync.sv
`timescale 1ns/10ps

// Two-flop synchroniser; the first stage feeds only the second.
module pin_sync #(
   parameter int          WIDTH     = 1,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rst,
   // Pins in, synchronised levels out
   input  wire logic [WIDTH-1:0] pin_in,
   output logic      [WIDTH-1:0] pin_sync_out
);

   logic [WIDTH-1:0] meta_r;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta_r       <= RESET_VAL;
         pin_sync_out <= RESET_VAL;
      end else begin
         meta_r       <= pin_in;
         pin_sync_out <= meta_r;
      end
   end

endmodule

//--- design/supply_supervisor_watchdog_reset.sv
`timescale 1ns/10ps

// Functional notes
// - Supply below threshold holds reset asserted.
// - Manual reset low holds reset asserted.
// - Watchdog expiry asserts reset.
// - Supply recovery keeps reset for hold time.
// - Manual release keeps reset for hold time.
// - Watchdog expires after 1.6 s unserviced.
// - Floating kick input disables watchdog.
// - Complementary reset outputs always agree.
// - Unconnected manual reset reads inactive high.
// - Hold time 140 to 280 ms, 200 nominal.
// - Watchdog time 1.12 to 2.40 s.
module supply_supervisor_watchdog_reset #(
   parameter int TICK_CYCLES = supervisor_pkg::TICK_CYCLES,
   parameter int HOLD_TICKS  = supervisor_pkg::RESET_HOLD_TICKS,
   parameter int WDOG_TICKS  = supervisor_pkg::WDOG_TICKS
) (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst,
   // Supply comparator result, high while supply is below threshold
   input  wire logic supply_low,
   // Manual reset pin, pulled up at the pad
   input  wire logic manual_reset_n,
   // Watchdog kick pin and its pad float detector
   input  wire logic watchdog_kick_in,
   input  wire logic watchdog_kick_float,
   // Reset outputs
   output logic      reset_out,
   output logic      reset_out_n
);

   // ------------------------------------------------------------------
   // Parameter checks
   // ------------------------------------------------------------------
   generate
      if (TICK_CYCLES < 2 || HOLD_TICKS < 1 || WDOG_TICKS < 1) begin : g_bad
         $error("supervisor timing parameters out of range");
      end
   endgenerate

   localparam int TW = $clog2(TICK_CYCLES);
   localparam int HW = $clog2(HOLD_TICKS + 1);
   localparam int WW = $clog2(WDOG_TICKS + 1);
   localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);
   localparam logic [HW-1:0] HOLD_LAST = HW'(HOLD_TICKS - 1);
   localparam logic [WW-1:0] WDOG_LAST = WW'(WDOG_TICKS - 1);

   // ------------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------------
   logic [3:0] pins_s;
   logic       supply_low_s;
   logic       mr_n_s;
   logic       kick_s;
   logic       float_s;

   // pull-up idle
   // The manual reset bit of the synchroniser starts at its inactive level so that an
   // undriven manual reset pin never reads as a request.
   pin_sync #(
      .WIDTH     (4),
      .RESET_VAL ({supervisor_pkg::SUPPLY_IDLE, supervisor_pkg::MR_IDLE,
                   supervisor_pkg::KICK_IDLE, supervisor_pkg::FLOAT_IDLE})
   ) u_sync (
      .clk          (clk),
      .rst          (rst),
      .pin_in       ({supply_low, manual_reset_n,
                      watchdog_kick_in, watchdog_kick_float}),
      .pin_sync_out (pins_s)
   );

   assign supply_low_s = pins_s[3];
   assign mr_n_s       = pins_s[2];
   assign kick_s       = pins_s[1];
   assign float_s      = pins_s[0];

   // ------------------------------------------------------------------
   // State
   // ------------------------------------------------------------------
   typedef struct packed {
      supervisor_pkg::sup_state_t state;
      logic [TW-1:0]              tick_cnt;
      logic [HW-1:0]              hold_cnt;
      logic [WW-1:0]              wd_cnt;
      logic                       kick_d;
      logic                       out_hi;
      logic                       out_lo;
   } sup_regs_t;

   sup_regs_t s_r;
   sup_regs_t s_nxt;
   logic      tick;
   logic      cause;
   logic      kick_edge;

   assign tick      = (s_r.tick_cnt == TICK_LAST);
   assign kick_edge = (kick_s != s_r.kick_d);

   always_comb begin
      s_nxt        = s_r;
      s_nxt.kick_d = kick_s;
      cause        = supply_low_s | ~mr_n_s;

      // The millisecond tick runs freely; alignment costs at most one
      // tick of hold time, well inside the permitted window.
      if (tick) begin
         s_nxt.tick_cnt = '0;
      end else begin
         s_nxt.tick_cnt = s_r.tick_cnt + TW'(1);
      end

      unique case (s_r.state)
         supervisor_pkg::ST_RESET: begin
            s_nxt.hold_cnt = '0;
            if (!cause) begin
               s_nxt.state = supervisor_pkg::ST_HOLD;
            end
         end
         supervisor_pkg::ST_HOLD: begin
            if (cause) begin
               s_nxt.state    = supervisor_pkg::ST_RESET;
               s_nxt.hold_cnt = '0;
            end else if (tick) begin
               if (s_r.hold_cnt == HOLD_LAST) begin
                  s_nxt.state    = supervisor_pkg::ST_RUN;
                  s_nxt.hold_cnt = '0;
               end else begin
                  s_nxt.hold_cnt = s_r.hold_cnt + HW'(1);
               end
            end
         end
         supervisor_pkg::ST_RUN: begin
            if (cause) begin
               s_nxt.state = supervisor_pkg::ST_RESET;
            end else if (float_s || kick_edge) begin
               s_nxt.wd_cnt = '0;
            end else if (tick) begin
               if (s_r.wd_cnt == WDOG_LAST) begin
                  s_nxt.state = supervisor_pkg::ST_HOLD;
               end else begin
                  s_nxt.wd_cnt = s_r.wd_cnt + WW'(1);
               end
            end
         end
      endcase

      if (s_nxt.state != supervisor_pkg::ST_RUN) begin
         s_nxt.wd_cnt = '0;
      end

      s_nxt.out_hi = (s_nxt.state != supervisor_pkg::ST_RUN);
      s_nxt.out_lo = ~s_nxt.out_hi;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_r.state    <= supervisor_pkg::ST_RESET;
         s_r.tick_cnt <= '0;
         s_r.hold_cnt <= '0;
         s_r.wd_cnt   <= '0;
         s_r.kick_d   <= supervisor_pkg::KICK_IDLE;
         s_r.out_hi   <= 1'h1;
         s_r.out_lo   <= 1'h0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign reset_out   = s_r.out_hi;
   assign reset_out_n = s_r.out_lo;

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   chk_supply_reset: assert property (
      @(posedge clk) disable iff (rst)
      supply_low_s |=> reset_out)
      else $error("reset not held while supply low");

   chk_manual_reset: assert property (
      @(posedge clk) disable iff (rst)
      !mr_n_s |=> reset_out && !reset_out_n)
      else $error("reset not held while manual reset low");

   chk_wdog_expiry: assert property (
      @(posedge clk) disable iff (rst)
      (s_r.state == supervisor_pkg::ST_RUN && tick && !cause && !float_s
       && !kick_edge && s_r.wd_cnt == WDOG_LAST)
      |=> reset_out && s_r.state == supervisor_pkg::ST_HOLD)
      else $error("watchdog expiry did not assert reset");

   chk_release_hold: assert property (
      @(posedge clk) disable iff (rst)
      $fell(reset_out) |-> $past(s_r.state) == supervisor_pkg::ST_HOLD
                           && $past(s_r.hold_cnt) == HOLD_LAST && $past(tick))
      else $error("reset released before hold time");

   chk_hold_restart: assert property (
      @(posedge clk) disable iff (rst)
      (cause && s_r.state == supervisor_pkg::ST_HOLD)
      |=> s_r.state == supervisor_pkg::ST_RESET && s_r.hold_cnt == '0)
      else $error("hold window not restarted by new cause");

   chk_wdog_bound: assert property (
      @(posedge clk) disable iff (rst)
      s_r.wd_cnt <= WDOG_LAST)
      else $error("watchdog count beyond expiry");

   chk_float_disable: assert property (
      @(posedge clk) disable iff (rst)
      float_s [*2] |-> s_r.wd_cnt == '0
                       && (!$rose(reset_out) || $past(cause)))
      else $error("watchdog counted while kick input floating");

   chk_outputs_agree: assert property (
      @(posedge clk) disable iff (rst)
      reset_out == !reset_out_n)
      else $error("reset outputs disagree");

   chk_kick_restart: assert property (
      @(posedge clk) disable iff (rst)
      (kick_edge && !cause && s_r.state == supervisor_pkg::ST_RUN)
      |=> s_r.wd_cnt == '0 && !reset_out)
      else $error("kick edge did not restart watchdog");

   chk_count_cleared: assert property (
      @(posedge clk) disable iff (rst)
      reset_out |-> s_r.wd_cnt == '0)
      else $error("watchdog counted during reset");

endmodule

//--- verification/kick_host.sv
`timescale 1ns/10ps

// Supervised processor: it kicks only while it is out of reset.
module kick_host (
   // Clock and reset seen by the processor
   input  wire logic       clk,
   input  wire logic       reset_out,
   // Bench control
   input  wire logic       kick_en,
   input  wire logic [3:0] kick_period,
   // Kick line
   output logic            kick
);
   int cnt = 0;

   initial kick = 1'h0;

   always @(negedge clk) begin
      cnt = cnt + 1;
      if (kick_en && !reset_out && cnt >= int'(kick_period)) begin
         kick <= ~kick;
         cnt = 0;
      end
   end
endmodule

//--- verification/supply_supervisor_watchdog_reset_bench.sv
`timescale 1ns/10ps

module supply_supervisor_watchdog_reset_bench;
   typedef struct {
      logic val;
      int   lo;
      int   hi;
   } note_t;
   logic       clk                 = 1'h0;
   logic       rst                 = 1'h1;
   logic       supply_low          = 1'h0;
   logic       manual_reset_n      = 1'h1;
   logic       watchdog_kick_float = 1'h0;
   logic       kick_en             = 1'h0;
   logic [3:0] kick_period         = 4'h4;
   logic       prev_r              = 1'h1;
   logic       watchdog_kick_in;
   logic       reset_out;
   logic       reset_out_n;
   int         cyc = 0;
   int         err_total = 0;
   int         total_checks = 0;
   int         seed = 76336;
   note_t      notes[$];
   note_t      n;

   always #25 clk = ~clk;

   // Short counts keep the run brief: tick of 4 cycles, 3 and 5 ticks.
   supply_supervisor_watchdog_reset #(
      .TICK_CYCLES(4),
      .HOLD_TICKS (3),
      .WDOG_TICKS (5)
   ) u_dut (
      .clk                (clk),
      .rst                (rst),
      .supply_low         (supply_low),
      .manual_reset_n     (manual_reset_n),
      .watchdog_kick_in   (watchdog_kick_in),
      .watchdog_kick_float(watchdog_kick_float),
      .reset_out          (reset_out),
      .reset_out_n        (reset_out_n)
   );

   kick_host u_host (
      .clk        (clk),
      .reset_out  (reset_out),
      .kick_en    (kick_en),
      .kick_period(kick_period),
      .kick       (watchdog_kick_in)
   );

   task automatic report_and_stop();
      if (err_total == 0 && total_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic expect_edge(input logic v, input int lo, input int hi);
      notes.push_back('{v, cyc + lo, cyc + hi});
   endtask

   task automatic wait_for(input logic v);
      int k;
      k = 0;
      while (reset_out !== v && k < 60) begin
         @(negedge clk);
         k++;
      end
      total_checks++;
      if (reset_out !== v) begin
         err_total++;
         $display("BAD %0t reset level never reached", $time);
      end
   endtask

   task automatic pulse_cause(input logic use_supply, input int len);
      @(negedge clk);
      supply_low     = use_supply;
      manual_reset_n = use_supply;
      expect_edge(1'h1, 1, 4);
      repeat (len) @(negedge clk);
      supply_low     = 1'h0;
      manual_reset_n = 1'h1;
      expect_edge(1'h0, 9, 16);
      wait_for(1'h0);
   endtask

   // ------------------------------------------------------------------
   // Watcher: every reset edge must match the oldest note.
   // ------------------------------------------------------------------
   always @(posedge clk) begin
      cyc++;
      if (cyc == 4000) begin
         err_total++;
         report_and_stop();
      end
   end

   always @(negedge clk) begin
      if (!rst) begin
         total_checks++;
         if (reset_out_n !== ~reset_out) begin
            err_total++;
            $display("BAD %0t outputs disagree", $time);
         end
         if (reset_out !== prev_r) begin
            total_checks++;
            if (notes.size() == 0) begin
               err_total++;
               $display("BAD %0t unexpected reset edge", $time);
            end else begin
               n = notes.pop_front();
               if (n.val !== reset_out || cyc < n.lo || cyc > n.hi) begin
                  err_total++;
                  $display("BAD %0t reset edge off its window", $time);
               end
            end
         end
      end
      prev_r = reset_out;
   end

   // ------------------------------------------------------------------
   // Stimulus
   // ------------------------------------------------------------------
   initial begin
      repeat (5) @(negedge clk);
      rst = 1'h0;
      expect_edge(1'h0, 9, 17);
      kick_en = 1'h1;
      wait_for(1'h0);
      for (int i = 0; i < 4; i++) begin
         kick_period = 4'(1 + ($unsigned($random(seed)) % 8));
         pulse_cause(1'(i), 2 + ($unsigned($random(seed)) % 20));
         repeat (30) @(negedge clk);
      end
      // A new cause inside the hold window must restart the whole hold.
      manual_reset_n = 1'h0;
      expect_edge(1'h1, 1, 4);
      repeat (3) @(negedge clk);
      manual_reset_n = 1'h1;
      repeat (2 + ($unsigned($random(seed)) % 7)) @(negedge clk);
      supply_low = 1'h1;
      repeat (2) @(negedge clk);
      supply_low = 1'h0;
      expect_edge(1'h0, 9, 16);
      wait_for(1'h0);
      repeat (30) @(negedge clk);
      // The second expiry starts from a release, so its count is fresh.
      for (int j = 0; j < 2; j++) begin
         kick_en = 1'h0;
         expect_edge(1'h1, j ? 15 : 10, j ? 23 : 25);
         wait_for(1'h1);
         kick_en = 1'(j);
         expect_edge(1'h0, 8, 14);
         wait_for(1'h0);
      end
      watchdog_kick_float = 1'h1;
      kick_en = 1'h0;
      repeat (60) @(negedge clk);
      kick_en = 1'h1;
      watchdog_kick_float = 1'h0;
      repeat (30) @(negedge clk);
      total_checks++;
      if (notes.size() != 0) begin
         err_total++;
         $display("BAD %0t expected reset edge missing", $time);
      end
      report_and_stop();
   end
endmodule
